// file: pkg/ipv_pkg.sv
// Constants, register map and source table of the interrupt priority block.
// Assumes a 32-bit APB register port with a 12-bit byte address.
package ipv_pkg;

    // Sizes
    localparam int NSRC    = 14;
    localparam int NREG    = 6;
    localparam int NEVT    = 2;
    localparam int PRIO_W  = 3;
    localparam int LEVEL_W = 4;
    localparam int CODE_W  = 7;
    localparam int ADDR_W  = 12;

    // Priority field values
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] A_PRIO_2   = 12'h000;
    localparam logic [ADDR_W-1:0] A_PRIO_3   = 12'h004;
    localparam logic [ADDR_W-1:0] A_PRIO_4   = 12'h008;
    localparam logic [ADDR_W-1:0] A_PRIO_5   = 12'h00C;
    localparam logic [ADDR_W-1:0] A_PRIO_7   = 12'h010;
    localparam logic [ADDR_W-1:0] A_PRIO_16  = 12'h014;
    localparam logic [ADDR_W-1:0] A_STATUS   = 12'h018;
    localparam logic [ADDR_W-1:0] A_EVT_STS  = 12'h01C;
    localparam logic [ADDR_W-1:0] A_EVT_CLR  = 12'h020;
    localparam logic [ADDR_W-1:0] A_EVT_EN   = 12'h024;

    // Priority registers by index 0..5
    localparam logic [NREG-1:0][ADDR_W-1:0] PRIO_ADDR =
        {A_PRIO_16, A_PRIO_7, A_PRIO_5, A_PRIO_4, A_PRIO_3, A_PRIO_2};

    // Status register field positions
    localparam int ST_LEVEL_LSB = 8;
    localparam int ST_CODE_LSB  = 0;

    // Event bits
    localparam int EVT_FWD     = 0;
    localparam int EVT_BLOCKED = 1;

    // Source table, index 0..13 (lower index = lower vector):
    // 0 timer three, 1 sync serial error, 2 sync serial event, 3 serial rx,
    // 4 serial tx, 5 converter done, 6 two-wire slave, 7 two-wire master,
    // 8 pin change, 9 ext irq one, 10 capture seven, 11 capture eight,
    // 12 ext irq two, 13 serial error
    localparam logic [NSRC-1:0][2:0] SRC_REG =
        {3'h5, 3'h4, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1,
         3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [NSRC-1:0][3:0] SRC_LSB =
        {4'h4, 4'h4, 4'hC, 4'h8, 4'h0, 4'hC, 4'h4, 4'h0, 4'h4, 4'h0,
         4'hC, 4'h8, 4'h4, 4'h0};
    localparam logic [NSRC-1:0][CODE_W-1:0] SRC_CODE =
        {7'h41, 7'h1D, 7'h17, 7'h16, 7'h14, 7'h13, 7'h12, 7'h11, 7'h0C, 7'h0B,
         7'h08, 7'h07, 7'h06, 7'h05};
    localparam int SRC_SERIAL_RX = 3;

    // Bus handshake phase, Gray along idle -> answer
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h0,
        BUS_ANSWER = 2'h1
    } ipv_bus_t;

endpackage : ipv_pkg

// file: pkg/ipv_sel_if.sv
// Request and winner signals between the register block and the resolver.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface ipv_sel_if;
    import ipv_pkg::*;
    logic [NSRC-1:0]             req;
    logic [NSRC-1:0][PRIO_W-1:0] prio;
    logic [LEVEL_W-1:0]          cur_level;
    logic                        hit;
    logic [3:0]                  idx;
    logic [LEVEL_W-1:0]          win_level;
    logic [CODE_W-1:0]           win_code;

    modport top (output req, prio, cur_level, input hit, idx, win_level, win_code);
    modport res (input req, prio, cur_level, output hit, idx, win_level, win_code);
endinterface : ipv_sel_if

// file: logic/ipv_resolver.sv
// Combinational selection of the winning interrupt source.
// Assumes requests are already gated by the source flag and enable bits.
`timescale 1ns/1ns
module ipv_resolver
    import ipv_pkg::*;
(
    // Request side and winner
    ipv_sel_if.res sel
);

    logic [LEVEL_W-1:0] lvl;

    // Ascending scan with strict compare keeps the lower vector on a tie
    always_comb begin
        lvl           = '0;
        sel.hit       = 1'b0;
        sel.idx       = '0;
        sel.win_level = '0;
        sel.win_code  = '0;
        for (int i = 0; i < NSRC; i++) begin
            lvl = {1'b0, sel.prio[i]};
            if (sel.req[i] && sel.prio[i] != PRIO_OFF
                && lvl > sel.cur_level
                && (!sel.hit || lvl > sel.win_level)) begin
                sel.hit       = 1'b1;
                sel.idx       = 4'(i);
                sel.win_level = lvl;
                sel.win_code  = SRC_CODE[i];
            end
        end
    end

endmodule : ipv_resolver

// file: logic/ipv_top.sv
// Top of the interrupt priority block: APB registers, status and events.
// Assumes src_req and cpu_level come from logic on clk.
`timescale 1ns/1ns
module ipv_top
    import ipv_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Peripheral sources, flag and enable already applied
    input  wire logic [NSRC-1:0]     src_req,
    // Processor core
    input  wire logic [LEVEL_W-1:0]  cpu_level,
    output logic                     cpu_irq_req,
    output logic      [LEVEL_W-1:0]  cpu_irq_level,
    output logic      [CODE_W-1:0]   cpu_irq_code,
    // Event interrupt
    output logic                     irq
);

    typedef struct packed {
        logic [NSRC-1:0][PRIO_W-1:0] prio;
        logic                        fwd_req;
        logic [LEVEL_W-1:0]          st_level;
        logic [CODE_W-1:0]           st_code;
        logic [NEVT-1:0]             evt_sts;
        logic [NEVT-1:0]             evt_en;
        ipv_bus_t                    bus;
        logic [31:0]                 rdata;
        logic                        slverr;
        logic                        irq;
        logic                        booted;
    } ipv_state_t;

    localparam ipv_state_t S_RESET = '{
        prio:     {NSRC{PRIO_RESET}},
        fwd_req:  1'b0,
        st_level: '0,
        st_code:  '0,
        evt_sts:  '0,
        evt_en:   '0,
        bus:      BUS_IDLE,
        rdata:    '0,
        slverr:   1'b0,
        irq:      1'b0,
        booted:   1'b0
    };

    ipv_state_t s_q;
    ipv_state_t s_d;

    ipv_sel_if sel ();

    logic              access;
    logic              done_wr;
    logic              rd_hit;
    logic [31:0]       rd_val;
    logic [NEVT-1:0]   evt_set;
    logic [NEVT-1:0]   evt_clr;
    logic              blocked;

    // Image of one priority register; bits with no field stay zero
    function automatic logic [15:0] prio_image(
        input logic [NSRC-1:0][PRIO_W-1:0] p,
        input logic [ADDR_W-1:0]           a
    );
        logic [15:0] img;
        img = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (a == PRIO_ADDR[SRC_REG[i]]) begin
                img[SRC_LSB[i] +: PRIO_W] = p[i];
            end
        end
        return img;
    endfunction : prio_image

    ipv_resolver u_resolver (
        .sel (sel.res)
    );

    // Resolver sees the live requests and the stored priorities
    always_comb begin
        sel.req       = src_req;
        sel.prio      = s_q.prio;
        sel.cur_level = cpu_level;
    end

    // Read decode, captured in the first access cycle
    always_comb begin
        rd_hit = 1'b0;
        rd_val = '0;
        for (int r = 0; r < NREG; r++) begin
            if (paddr == PRIO_ADDR[r]) begin
                rd_hit = 1'b1;
            end
        end
        rd_val[15:0] = prio_image(s_q.prio, paddr);
        if (paddr == A_STATUS) begin
            rd_hit = 1'b1;
            rd_val[ST_LEVEL_LSB +: LEVEL_W] = s_q.st_level;
            rd_val[ST_CODE_LSB +: CODE_W]   = s_q.st_code;
        end
        if (paddr == A_EVT_STS) begin
            rd_hit               = 1'b1;
            rd_val[NEVT-1:0]     = s_q.evt_sts;
        end
        if (paddr == A_EVT_EN) begin
            rd_hit               = 1'b1;
            rd_val[NEVT-1:0]     = s_q.evt_en;
        end
        if (paddr == A_EVT_CLR) begin
            rd_hit = 1'b1;                                     // Write-only, reads zero
        end
    end

    // Event sources
    always_comb begin
        blocked = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (src_req[i] && s_q.prio[i] == PRIO_OFF) begin
                blocked = 1'b1;
            end
        end
        evt_set              = '0;
        evt_set[EVT_FWD]     = sel.hit && (!s_q.fwd_req || sel.win_code != s_q.st_code);
        evt_set[EVT_BLOCKED] = blocked;
    end

    // Next state: bus handshake, register writes, status and events
    always_comb begin
        s_d     = s_q;
        access  = psel && penable;
        done_wr = access && pwrite && s_q.bus == BUS_ANSWER;
        evt_clr = '0;

        // One wait cycle so read data leaves a flop
        case (s_q.bus)
            BUS_IDLE: begin
                if (access) begin
                    s_d.bus    = BUS_ANSWER;
                    s_d.rdata  = pwrite ? 32'h0000_0000 : rd_val;
                    s_d.slverr = !rd_hit;
                end
            end
            BUS_ANSWER: begin
                s_d.bus    = BUS_IDLE;
                s_d.rdata  = '0;
                s_d.slverr = 1'b0;
            end
            default: begin
                s_d.bus    = BUS_IDLE;
                s_d.rdata  = '0;
                s_d.slverr = 1'b0;
            end
        endcase

        // Writes land only in implemented fields
        if (done_wr) begin
            for (int i = 0; i < NSRC; i++) begin
                if (paddr == PRIO_ADDR[SRC_REG[i]]) begin
                    s_d.prio[i] = pwdata[SRC_LSB[i] +: PRIO_W];
                end
            end
            if (paddr == A_EVT_EN) begin
                s_d.evt_en = pwdata[NEVT-1:0];
            end
            if (paddr == A_EVT_CLR) begin
                evt_clr = pwdata[NEVT-1:0];
            end
        end

        // Status follows the resolver; software cannot write it
        s_d.fwd_req  = sel.hit;
        s_d.st_level = sel.hit ? sel.win_level : '0;
        s_d.st_code  = sel.hit ? sel.win_code  : '0;

        // A set in the same cycle as its clear survives
        s_d.evt_sts = (s_q.evt_sts & ~evt_clr) | evt_set;
        s_d.irq     = |(s_d.evt_sts & s_d.evt_en);
        s_d.booted  = 1'b1;
    end

    // Single state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= S_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata        = s_q.rdata;
    assign pready        = s_q.bus[0];                        // Set only in the answer phase
    assign pslverr       = s_q.slverr;
    assign cpu_irq_req   = s_q.fwd_req;
    assign cpu_irq_level = s_q.st_level;
    assign cpu_irq_code  = s_q.st_code;
    assign irq           = s_q.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Fields and status come out of reset at their documented values
    a_reset_prio_four: assert property (
        !s_q.booted |-> (s_q.prio == {NSRC{PRIO_RESET}} && s_q.st_level == '0 && s_q.st_code == '0))
        else $error("priority fields or status wrong after reset");

    // A completed write lands in the serial receive field
    a_write_lands_rx: assert property (
        (psel && penable && pready && pwrite && paddr == A_PRIO_2)
        |=> s_q.prio[SRC_SERIAL_RX] == $past(pwdata[SRC_LSB[SRC_SERIAL_RX] +: PRIO_W]))
        else $error("serial receive priority not written");

    // Status reads keep unimplemented bits at zero
    a_status_unimpl_zero: assert property (
        (psel && penable && pready && !pwrite && paddr == A_STATUS)
        |-> (prdata[31:ST_LEVEL_LSB + LEVEL_W] == '0 && prdata[ST_CODE_LSB + CODE_W] == 1'b0))
        else $error("status unimplemented bits not zero");

    // Control 3 reads nothing above bit 6
    a_ctrl3_upper_zero: assert property (
        (psel && penable && pready && !pwrite && paddr == A_PRIO_3) |-> prdata[31:7] == '0)
        else $error("control 3 upper bits not zero");

    // A disabled source never wins
    a_off_never_wins: assert property (
        sel.hit |-> s_q.prio[sel.idx] != PRIO_OFF)
        else $error("disabled source selected");

    // Winner strictly above the current cpu level
    a_win_above_cpu: assert property (
        sel.hit |-> (sel.win_level > cpu_level && sel.win_level <= {1'b0, 3'h7}))
        else $error("winner not above cpu level");

    // Status shows the winner one cycle later
    a_status_tracks: assert property (
        sel.hit |=> (cpu_irq_req && cpu_irq_level == $past(sel.win_level)
                     && cpu_irq_code == $past(sel.win_code)))
        else $error("status does not track winner");

    // Event set beats a simultaneous clear
    a_set_beats_clear: assert property (
        (done_wr && paddr == A_EVT_CLR && pwdata[EVT_BLOCKED] && blocked)
        |=> s_q.evt_sts[EVT_BLOCKED])
        else $error("event lost to clear");

    // Status writes are accepted without error and change no field
    a_status_write_ok: assert property (
        (psel && penable && pready && pwrite && paddr == A_STATUS)
        |-> (!pslverr && s_d.prio == s_q.prio))
        else $error("status write had an effect");

    // Answer lasts exactly one cycle
    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("pready longer than one cycle");

endmodule : ipv_top

// file: bench/ipv_src_model.sv
// Stand-in for the peripheral sources and the processor core.
// Assumes the bench sets the wanted requests and level; both launch on clk.
`timescale 1ns/1ns
module ipv_src_model
    import ipv_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Bench commands
    input  wire logic [NSRC-1:0]    want_req,
    input  wire logic [LEVEL_W-1:0] want_level,
    // Toward the block
    output logic      [NSRC-1:0]    src_req,
    output logic      [LEVEL_W-1:0] cpu_level
);
    // Launched off the block's clock, like a synchronous peripheral
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_req   <= '0;
            cpu_level <= '0;
        end else begin
            src_req   <= want_req;
            cpu_level <= want_level;
        end
    end
endmodule : ipv_src_model

// file: bench/tb_top.sv
// Self-checking bench of the interrupt priority block.
// Assumes the package, interface, design and source model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    import ipv_pkg::*;
    logic                clk = 1'b0;
    logic                arst_n = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [31:0]         pwdata = '0;
    logic [31:0]         prdata;
    logic                pready, pslverr, cpu_irq_req, irq;
    logic [NSRC-1:0]     want_req = '0;
    logic [LEVEL_W-1:0]  want_level = '0;
    logic [NSRC-1:0]     src_req;
    logic [LEVEL_W-1:0]  cpu_level, cpu_irq_level;
    logic [CODE_W-1:0]   cpu_irq_code;
    logic [31:0]         v;
    logic                e;
    int                  failures = 0;
    int                  n_tests = 0;
    // Implemented field bits of each priority register, index 0..5
    localparam logic [NREG-1:0][15:0] MASK =
        {16'h0070, 16'h0070, 16'h7707, 16'h7077, 16'h0077, 16'h7777};

    // 250 MHz clock
    always #2 clk = ~clk;

    ipv_top dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .cpu_level(cpu_level), .cpu_irq_req(cpu_irq_req),
        .cpu_irq_level(cpu_irq_level), .cpu_irq_code(cpu_irq_code), .irq(irq));
    ipv_src_model peer (.clk(clk), .arst_n(arst_n), .want_req(want_req), .want_level(want_level),
        .src_req(src_req), .cpu_level(cpu_level));

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        v = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Apply source requests and core level, then let them settle
    task automatic drive(input logic [NSRC-1:0] r, input logic [LEVEL_W-1:0] l);
        @(posedge clk);
        want_req   <= r;
        want_level <= l;
        repeat (4) @(posedge clk);
        #1;
    endtask : drive

    // Reset values of all fields and the status register
    task automatic t_reset();
        for (int i = 0; i < NREG; i++) begin
            apb(1'b0, PRIO_ADDR[i], '0);
            `CHK(v, {16'h0, MASK[i] & 16'h4444})
        end
        apb(1'b0, A_STATUS, '0);
        `CHK(v, 32'h0)
        $display("test reset done");
    endtask : t_reset

    // All-ones writes keep only implemented bits; status writes ignored, unmapped reads refused
    task automatic t_mask();
        for (int i = 0; i < NREG; i++) begin
            apb(1'b1, PRIO_ADDR[i], 32'hFFFFFFFF);
            apb(1'b0, PRIO_ADDR[i], '0);
            `CHK(v, {16'h0, MASK[i]})
        end
        apb(1'b1, A_STATUS, 32'hFFFFFFFF);
        apb(1'b0, A_STATUS, '0);
        `CHK(v, 32'h0)
        apb(1'b0, 12'h0FC, '0);
        `CHK({e, v}, {1'b1, 32'h0})
        for (int i = 0; i < NREG; i++) apb(1'b1, PRIO_ADDR[i], 32'h0);
        $display("test mask done");
    endtask : t_mask

    // Forwarded winner at the core port and in the status register
    task automatic chk_win(input int idx, input logic [LEVEL_W-1:0] l);
        logic [CODE_W-1:0] c;
        c = (idx < 0) ? '0 : SRC_CODE[idx];
        `CHK({cpu_irq_req, cpu_irq_level, cpu_irq_code}, {idx >= 0, l, c})
        apb(1'b0, A_STATUS, '0);
        `CHK(v, {20'h0, l, 1'b0, c})
    endtask : chk_win

    // Every enabled priority code, ties, core level masking
    task automatic t_arb();
        for (int p = 1; p < 8; p++) begin
            apb(1'b1, A_PRIO_2, {29'h0, p[2:0]});
            drive(14'h0001, 4'h0);
            chk_win(0, p[3:0]);
        end
        apb(1'b1, A_PRIO_2, 32'h5003);
        apb(1'b1, A_PRIO_7, 32'h0050);
        apb(1'b1, A_PRIO_4, 32'h7000);
        drive(14'h1009, 4'h0);
        chk_win(3, 4'h5);
        drive(14'h1109, 4'h0);
        chk_win(8, 4'h7);
        drive(14'h1109, 4'h7);
        chk_win(-1, 4'h0);
        drive(14'h1009, 4'h5);
        chk_win(-1, 4'h0);
        drive(14'h1001, 4'h3);
        chk_win(12, 4'h5);
        apb(1'b0, A_EVT_STS, '0);
        `CHK(v[EVT_FWD], 1'b1)
        drive(14'h0, 4'h0);
        $display("test arbitration done");
    endtask : t_arb

    // Disabled source never forwarded; event raise, mask and clear
    task automatic t_off_irq();
        apb(1'b1, A_PRIO_2, 32'h0);
        apb(1'b1, A_EVT_CLR, 32'h3);
        apb(1'b1, A_EVT_EN, 32'h2);
        drive(14'h0001, 4'h0);
        `CHK({cpu_irq_req, irq}, 2'b01)
        apb(1'b0, A_EVT_STS, '0);
        `CHK(v[1], 1'b1)
        apb(1'b1, A_EVT_EN, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        // Clear while the blocked source still requests: the set must win
        apb(1'b1, A_EVT_CLR, 32'h2);
        apb(1'b0, A_EVT_STS, '0);
        `CHK(v[EVT_BLOCKED], 1'b1)
        drive(14'h0, 4'h0);
        apb(1'b1, A_EVT_CLR, 32'h3);
        apb(1'b0, A_EVT_STS, '0);
        `CHK(v, 32'h0)
        $display("test disable and event done");
    endtask : t_off_irq

    // Each source wins only through its own field
    task automatic t_map();
        for (int i = 0; i < NSRC; i++) begin
            for (int r = 0; r < NREG; r++) apb(1'b1, PRIO_ADDR[r], 32'h0);
            apb(1'b1, PRIO_ADDR[SRC_REG[i]], 32'h7 << SRC_LSB[i]);
            drive({NSRC{1'b1}}, 4'h0);
            chk_win(i, 4'h7);
        end
        drive('0, 4'h0);
        $display("test field map done");
    endtask : t_map

    // Reset pulse in mid-run brings every field back to its reset value
    task automatic t_rerun_reset();
        apb(1'b1, A_PRIO_2, 32'h7777);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        `CHK({cpu_irq_req, irq, cpu_irq_level, cpu_irq_code}, 13'h0)
        t_reset();
    endtask : t_rerun_reset

    // Verdict in one place
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_mask();
        t_arb();
        t_off_irq();
        t_map();
        t_rerun_reset();
        tally_and_finish();
    end

    // Watchdog, far beyond the roughly 900 cycles the tests need
    initial begin
        #80000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
